// ---- spwm_channel.sv ----
`timescale 1ns/10ps
// What this block does
// - drive one output pin with a pwm wave of up to 10-bit resolution
// - writing zero to channel control releases control of the output pin
// - period comes from one of three 8-bit timers picked by a 2-bit field
// - period is (period+1) times 4 oscillator periods times prescale
// - after count equals period: clear count, latch duty, set pin unless zero
// - timer postscaler does not affect the wave frequency
// - 10-bit duty is upper byte plus two lower bits in control register
// - duty writes accepted anytime, used only after a period match
// - shadow duty register is read-only while in pwm mode
// - duty is double buffered by shadow register and 2-bit latch
// - time base is count with two low bits from cycle counter or prescaler
// - time base equal to latched duty drives the pin low
// - high time is duty times oscillator period times prescale
// - duty beyond the period never clears the pin in that period
// - prescale factors 1, 4 and 16 are supported
// - resolution is log2 of 4(period+1), 10 bits at period 255
// - in sleep all counting and state freeze, pin holds, resume after
// - any reset restores register reset values and sets pins to input
module spwm_channel (
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       sleep,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   output logic            pwm_output_pin,
   output logic            pwm_output_oe
);
   import spwm_pkg::*;

   logic [7:0]  channel_control_reg_r;
   logic [7:0]  duty_upper_reg_r;
   logic [7:0]  duty_shadow_reg_r;
   logic [1:0]  duty_lsb_latch_r;
   logic [7:0]  period_reg_r [NUM_TMR];
   logic [7:0]  timer_control_reg_r [NUM_TMR];
   logic [7:0]  timer_count_r [NUM_TMR];
   logic [3:0]  presc_r [NUM_TMR];
   logic [NUM_TMR-1:0] timer_match_flag_r;
   logic [7:0]  timer_select_reg_r;
   logic        pin_direction_bit_r;
   logic        pwm_level_r;
   logic        started_r;
   spwm_state_t state_r;
   logic [NUM_TMR-1:0] tick;
   logic [NUM_TMR-1:0] match;
   logic [1:0]  sel;
   logic [1:0]  sel_ckps;
   logic [9:0]  time_base;
   logic [9:0]  duty_latched;
   logic        pwm_mode;
   logic        run;

   // write strobes decoded per register
   logic        wr_ctrl;
   logic        wr_duty_up;
   logic        wr_duty_shd;
   logic        wr_period;
   logic        wr_tctrl;
   logic        wr_tsel;
   logic        wr_tcount;
   logic        wr_flags;
   logic        wr_dir;

   // time base stepping and period end
   logic        period_end;
   logic        tb_step;
   logic [9:0]  tb_next;
   logic        duty_zero;

   // prescaler terminal count for a prescale field
   function automatic logic [3:0] presc_last(input logic [1:0] ckps);
      if (ckps == CKPS_1) begin
         presc_last = 4'h0;
      end else if (ckps == CKPS_4) begin
         presc_last = 4'h3;
      end else begin
         presc_last = 4'hF;
      end
   endfunction

   // two low time-base bits taken from the prescaler
   function automatic logic [1:0] presc_bits(input logic [1:0] ckps, input logic [3:0] p);
      if (ckps == CKPS_4) begin
         presc_bits = p[1:0];
      end else begin
         presc_bits = p[3:2];
      end
   endfunction

   // time base advances on this edge for the given prescale
   function automatic logic tb_advance(input logic [1:0] ckps, input logic [1:0] q,
                                       input logic [3:0] p);
      if (ckps == CKPS_1) begin
         tb_advance = 1'b1;
      end else if (ckps == CKPS_4) begin
         tb_advance = (q == Q_LAST);
      end else begin
         tb_advance = (q == Q_LAST) && (p[1:0] == Q_LAST);
      end
   endfunction

   assign run      = ~sleep;
   assign pwm_mode = (channel_control_reg_r[CTRL_MODE_LSB +: 4] == MODE_PWM);
   assign sel      = (timer_select_reg_r[TSEL_W-1:0] < 2'(NUM_TMR)) ?
                     timer_select_reg_r[TSEL_W-1:0] : 2'h0;

   // oscillator-cycle counter: one timer clock every four ref_clk cycles
   logic [1:0] q_cnt_r;
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         q_cnt_r <= 2'h0;
      end else if (run) begin
         q_cnt_r <= q_cnt_r + 2'h1;
      end
   end

   // three period timers with prescaler; postscaler bits have no effect
   genvar g;
   for (g = 0; g < NUM_TMR; g++) begin : g_tmr
      logic [1:0] ckps;
      assign ckps    = timer_control_reg_r[g][TCTRL_CKPS_LSB +: 2];
      assign tick[g] = run && timer_control_reg_r[g][TCTRL_ON_BIT] && (q_cnt_r == Q_LAST)
                       && (presc_r[g] == presc_last(ckps));
      assign match[g] = (timer_count_r[g] == period_reg_r[g]);
      always_ff @(posedge ref_clk) begin
         if (reset) begin
            presc_r[g] <= 4'h0;
         end else if (run && timer_control_reg_r[g][TCTRL_ON_BIT] && q_cnt_r == Q_LAST) begin
            presc_r[g] <= (presc_r[g] == presc_last(ckps)) ? 4'h0 : presc_r[g] + 4'h1;
         end
      end
      always_ff @(posedge ref_clk) begin
         if (reset) begin
            timer_count_r[g] <= RST_BYTE;
         end else if (wr_tcount && sel == 2'(g)) begin
            timer_count_r[g] <= reg_wdata;
         end else if (tick[g]) begin
            timer_count_r[g] <= match[g] ? RST_BYTE : timer_count_r[g] + 8'h01;
         end
      end
      always_ff @(posedge ref_clk) begin
         if (reset) begin
            timer_match_flag_r[g] <= 1'b0;
         end else if (tick[g] && match[g]) begin
            timer_match_flag_r[g] <= 1'b1;
         end else if (wr_flags && !reg_wdata[g]) begin
            timer_match_flag_r[g] <= 1'b0;
         end
      end
   end

   // write address decode
   always_comb begin
      wr_ctrl     = 1'b0;
      wr_duty_up  = 1'b0;
      wr_duty_shd = 1'b0;
      wr_period   = 1'b0;
      wr_tctrl    = 1'b0;
      wr_tsel     = 1'b0;
      wr_tcount   = 1'b0;
      wr_flags    = 1'b0;
      wr_dir      = 1'b0;
      if (reg_wr) begin
         if (reg_addr == ADDR_CTRL) begin
            wr_ctrl = 1'b1;
         end else if (reg_addr == ADDR_DUTY_UP) begin
            wr_duty_up = 1'b1;
         end else if (reg_addr == ADDR_DUTY_SHD) begin
            wr_duty_shd = 1'b1;
         end else if (reg_addr == ADDR_PERIOD) begin
            wr_period = 1'b1;
         end else if (reg_addr == ADDR_TCTRL) begin
            wr_tctrl = 1'b1;
         end else if (reg_addr == ADDR_TSEL) begin
            wr_tsel = 1'b1;
         end else if (reg_addr == ADDR_TCOUNT) begin
            wr_tcount = 1'b1;
         end else if (reg_addr == ADDR_FLAGS) begin
            wr_flags = 1'b1;
         end else if (reg_addr == ADDR_DIR) begin
            wr_dir = 1'b1;
         end
      end
   end

   // channel control
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         channel_control_reg_r <= RST_BYTE;
      end else if (wr_ctrl) begin
         channel_control_reg_r <= reg_wdata;
      end
   end

   // upper duty byte
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         duty_upper_reg_r <= RST_BYTE;
      end else if (wr_duty_up) begin
         duty_upper_reg_r <= reg_wdata;
      end
   end

   // timer select
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         timer_select_reg_r <= RST_BYTE;
      end else if (wr_tsel) begin
         timer_select_reg_r <= reg_wdata;
      end
   end

   // pin direction, input after reset
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pin_direction_bit_r <= RST_DIR[0];
      end else if (wr_dir) begin
         pin_direction_bit_r <= reg_wdata[0];
      end
   end

   // period register of the selected timer
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         for (int i = 0; i < NUM_TMR; i++) begin
            period_reg_r[i] <= RST_PERIOD;
         end
      end else if (wr_period) begin
         period_reg_r[sel] <= reg_wdata;
      end
   end

   // timer control of the selected timer
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         for (int i = 0; i < NUM_TMR; i++) begin
            timer_control_reg_r[i] <= RST_BYTE;
         end
      end else if (wr_tctrl) begin
         timer_control_reg_r[sel] <= reg_wdata;
      end
   end

   assign period_end = tick[sel] && match[sel];
   assign duty_zero  = ({duty_upper_reg_r, channel_control_reg_r[CTRL_DCB_LSB +: 2]} == 10'h000);

   // shadow duty byte: writable outside pwm mode, loaded at period end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         duty_shadow_reg_r <= RST_BYTE;
      end else if (pwm_mode && period_end) begin
         duty_shadow_reg_r <= duty_upper_reg_r;
      end else if (wr_duty_shd && !pwm_mode) begin
         duty_shadow_reg_r <= reg_wdata;
      end
   end

   // two-bit duty latch, loaded with the shadow byte
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         duty_lsb_latch_r <= 2'h0;
      end else if (pwm_mode && period_end) begin
         duty_lsb_latch_r <= channel_control_reg_r[CTRL_DCB_LSB +: 2];
      end
   end

   // 10-bit time base and compare
   assign sel_ckps     = timer_control_reg_r[sel][TCTRL_CKPS_LSB +: 2];
   assign time_base    = {timer_count_r[sel], (sel_ckps == CKPS_1) ? q_cnt_r :
                          presc_bits(sel_ckps, presc_r[sel])};
   assign duty_latched = {duty_shadow_reg_r, duty_lsb_latch_r};
   // pin falls as the time base steps onto the duty value
   assign tb_step      = run && timer_control_reg_r[sel][TCTRL_ON_BIT] &&
                         tb_advance(sel_ckps, q_cnt_r, presc_r[sel]);
   assign tb_next      = time_base + 10'h001;

   // channel state: off outside pwm mode, then running
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_r <= SPWM_OFF;
      end else if (!pwm_mode) begin
         state_r <= SPWM_OFF;
      end else if (run) begin
         case (state_r)
            SPWM_OFF: begin
               state_r <= SPWM_RUN;
            end
            default: begin
               state_r <= SPWM_RUN;
            end
         endcase
      end
   end

   // started flag for status
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         started_r <= 1'b0;
      end else if (!pwm_mode) begin
         started_r <= 1'b0;
      end else if (run && state_r == SPWM_OFF) begin
         started_r <= 1'b1;
      end
   end

   // waveform level
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pwm_level_r <= 1'b0;
      end else if (!pwm_mode) begin
         pwm_level_r <= 1'b0;
      end else if (run && state_r == SPWM_RUN) begin
         if (period_end) begin
            pwm_level_r <= !duty_zero;
         end else if (tb_step && tb_next == duty_latched) begin
            pwm_level_r <= 1'b0;
         end
      end
   end

   // pin level
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pwm_output_pin <= 1'b0;
      end else if (run) begin
         pwm_output_pin <= pwm_level_r;
      end
   end

   // pin driver enable
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pwm_output_oe <= 1'b0;
      end else if (run) begin
         pwm_output_oe <= pwm_mode && !pin_direction_bit_r;
      end
   end

   // register reads, data one cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         reg_rdata <= RST_BYTE;
      end else if (reg_rd) begin
         if (reg_addr == ADDR_CTRL) begin
            reg_rdata <= channel_control_reg_r;
         end else if (reg_addr == ADDR_DUTY_UP) begin
            reg_rdata <= duty_upper_reg_r;
         end else if (reg_addr == ADDR_DUTY_SHD) begin
            reg_rdata <= duty_shadow_reg_r;
         end else if (reg_addr == ADDR_PERIOD) begin
            reg_rdata <= period_reg_r[sel];
         end else if (reg_addr == ADDR_TCTRL) begin
            reg_rdata <= timer_control_reg_r[sel];
         end else if (reg_addr == ADDR_TSEL) begin
            reg_rdata <= timer_select_reg_r;
         end else if (reg_addr == ADDR_TCOUNT) begin
            reg_rdata <= timer_count_r[sel];
         end else if (reg_addr == ADDR_FLAGS) begin
            reg_rdata <= {5'h00, timer_match_flag_r};
         end else if (reg_addr == ADDR_DIR) begin
            reg_rdata <= {7'h00, pin_direction_bit_r};
         end else if (reg_addr == ADDR_STATUS) begin
            reg_rdata <= {5'h00, started_r, pwm_mode, pwm_level_r};
         end else begin
            reg_rdata <= RST_BYTE;
         end
      end else begin
         reg_rdata <= RST_BYTE;
      end
   end
endmodule

// ---- spwm_channel_monitor.sv ----
`timescale 1ns/10ps
module spwm_channel_monitor (
   input wire logic       ref_clk,
   input wire logic       reset,
   input wire logic       sleep,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       pwm_output_pin,
   input wire logic       pwm_output_oe
);
   import spwm_pkg::*;
   logic dir_r;
   logic pwm_r;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   always_ff @(posedge ref_clk) begin
      if (reset) dir_r <= 1'b1;
      else if (reg_wr && reg_addr == ADDR_DIR) dir_r <= reg_wdata[0];
   end
   always_ff @(posedge ref_clk) begin
      if (reset) pwm_r <= 1'b0;
      else if (reg_wr && reg_addr == ADDR_CTRL) pwm_r <= (reg_wdata[3:0] == MODE_PWM);
   end
   a_reset_pin_off: assert property ($past(reset) |-> !pwm_output_oe && !pwm_output_pin)
      else $error("pin active after reset");
   a_sleep_pin_hold: assert property (sleep && $past(sleep) && $past(sleep, 2) &&
      $past(sleep, 3) |-> $stable(pwm_output_pin)) else $error("pin moved in sleep");
   a_ctrl_clear_release: assert property (reg_wr && reg_addr == ADDR_CTRL &&
      reg_wdata == 8'h00 |-> ##[1:3] (!pwm_output_oe && !pwm_output_pin))
      else $error("pin kept after control clear");
   a_dir_read_back: assert property (reg_rd && reg_addr == ADDR_DIR |=>
      reg_rdata[0] == $past(dir_r)) else $error("direction bit read wrong");
   a_oe_needs_dir: assert property (pwm_output_oe |-> !$past(dir_r) || !$past(dir_r, 2))
      else $error("driver on while direction is input");
   a_oe_needs_mode: assert property (pwm_output_oe |-> $past(pwm_r) || $past(pwm_r, 2))
      else $error("driver on outside pwm mode");
   a_mode_off_quiet: assert property (!pwm_r && !$past(pwm_r) && !$past(pwm_r, 2) |->
      !pwm_output_pin && !pwm_output_oe) else $error("pin active outside pwm mode");
   a_rise_min_period: assert property ($rose(pwm_output_pin) |=>
      !$rose(pwm_output_pin) [*3]) else $error("period shorter than four cycles");
   cover property (pwm_output_oe && $rose(pwm_output_pin));
   cover property (sleep && pwm_output_pin);
   cover property ($fell(pwm_output_oe));
endmodule
bind spwm_channel spwm_channel_monitor u_mon (.ref_clk(ref_clk), .reset(reset), .sleep(sleep),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .pwm_output_pin(pwm_output_pin), .pwm_output_oe(pwm_output_oe));

// ---- spwm_channel_test.sv ----
`timescale 1ns/10ps
module spwm_channel_test;
   import spwm_pkg::*;
   logic        ref_clk, reset, sleep, reg_wr, reg_rd, pad, pwm_output_pin, pwm_output_oe;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, d;
   logic [15:0] per_cnt, hi_cnt, bad;
   int          fails, tests_run, seed, pr, dv, ps;
   spwm_channel u_dut (.ref_clk(ref_clk), .reset(reset), .sleep(sleep), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .pwm_output_pin(pwm_output_pin), .pwm_output_oe(pwm_output_oe));
   spwm_load_model u_load (.ref_clk(ref_clk), .pwm_output_pin(pwm_output_pin),
      .pwm_output_oe(pwm_output_oe), .pad(pad), .per_cnt(per_cnt), .hi_cnt(hi_cnt));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk_cnt(string nm, logic [15:0] e, logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [3:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic chk_reg(string nm, logic [3:0] a, logic [7:0] e);
      rd(a);
      chk_cnt(nm, {8'h00, e}, {8'h00, d});
   endtask
   task automatic rst_vals();
      chk_cnt("oe", 16'h0000, {15'h0000, pwm_output_oe});
      chk_reg("dir", ADDR_DIR, RST_DIR);
      chk_reg("period", ADDR_PERIOD, RST_PERIOD);
      chk_reg("ctrl", ADDR_CTRL, RST_BYTE);
      chk_reg("shadow", ADDR_DUTY_SHD, RST_BYTE);
   endtask
   task automatic cfg(int t, int p, int v, int ck, int po);
      wr(ADDR_DIR, 8'h01);
      wr(ADDR_TSEL, 8'(t));
      wr(ADDR_PERIOD, 8'(p));
      wr(ADDR_CTRL, {2'h0, 2'(v), MODE_PWM});
      wr(ADDR_DUTY_UP, 8'(v >> 2));
      wr(ADDR_FLAGS, 8'h00);
      wr(ADDR_TCTRL, 8'((po << 3) | 4 | ck));
      d = 8'h00;
      for (int n = 0; n < 1500 && d[t] !== 1'b1; n++) rd(ADDR_FLAGS);
      wr(ADDR_DIR, 8'h00);
   endtask
   initial begin
      repeat (80000) @(posedge ref_clk);
      fails++;
      report_and_stop();
   end
   initial begin
      seed = 49837;
      reset = 1'b1;
      sleep = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      fails = 0;
      tests_run = 0;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      rst_vals();
      for (int i = 0; i < 5; i++) begin
         pr = (i < 3) ? ($random(seed) & 15) : 255;
         dv = (i == 3) ? 1023 : (i == 4) ? 1 : 1 + ($unsigned($random(seed)) % (4 * pr + 3));
         ps = (i < 3) ? (1 << (2 * i)) : 1;
         cfg(i % 3, pr, dv, (i < 3) ? i : 0, $random(seed) & 15);
         repeat (12 * (pr + 1) * ps + 20) @(posedge ref_clk);
         chk_cnt("period", 16'(4 * (pr + 1) * ps), per_cnt);
         chk_cnt("high", 16'(dv * ps), hi_cnt);
      end
      @(posedge pad);
      wr(ADDR_DUTY_UP, 8'h40);
      wr(ADDR_DUTY_SHD, 8'h55);
      chk_reg("shadow", ADDR_DUTY_SHD, 8'h00);
      repeat (2100) @(posedge ref_clk);
      chk_reg("shadow", ADDR_DUTY_SHD, 8'h40);
      chk_cnt("high", 16'h0101, hi_cnt);
      @(posedge ref_clk);
      sleep <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(ADDR_TCOUNT);
      pr = d;
      repeat (60) @(posedge ref_clk);
      chk_reg("count", ADDR_TCOUNT, 8'(pr));
      @(posedge ref_clk);
      sleep <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         wr(ADDR_CTRL, 8'h00);
         repeat (3) @(posedge ref_clk);
         chk_cnt("oe", 16'h0000, {15'h0000, pwm_output_oe});
         cfg(0, 3, k * 1023, 0, 0);
         repeat (40) @(posedge ref_clk);
         bad = 16'h0000;
         repeat (32) begin
            @(posedge ref_clk);
            #1;
            if (pwm_output_pin !== 1'(k)) bad++;
         end
         chk_cnt("level", 16'h0000, bad);
         chk_reg("status", ADDR_STATUS, 8'h06 | 8'(k));
      end
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      rst_vals();
      report_and_stop();
   end
endmodule

// ---- spwm_load_model.sv ----
`timescale 1ns/10ps
module spwm_load_model (
   input  wire logic        ref_clk,
   input  wire logic        pwm_output_pin,
   input  wire logic        pwm_output_oe,
   output logic             pad,
   output logic [15:0]      per_cnt,
   output logic [15:0]      hi_cnt
);
   logic [15:0] cnt;
   logic        pad_q;
   // an undriven pad floats, shown as a level that flips every cycle
   assign pad = pwm_output_oe ? pwm_output_pin : ~pad_q;
   initial begin
      pad_q = 1'b0;
      cnt = 16'h0000;
      per_cnt = 16'h0000;
      hi_cnt = 16'h0000;
   end
   always @(posedge ref_clk) begin
      pad_q <= (pad === 1'b1);
      cnt <= (pad && !pad_q) ? 16'h0001 : cnt + 16'h0001;
      if (pad && !pad_q) per_cnt <= cnt;
      if (!pad && pad_q) hi_cnt <= cnt;
   end
endmodule

// ---- spwm_pkg.sv ----
package spwm_pkg;
   // register indices on the plain register port
   localparam logic [3:0] ADDR_CTRL      = 4'h0;
   localparam logic [3:0] ADDR_DUTY_UP   = 4'h1;
   localparam logic [3:0] ADDR_DUTY_SHD  = 4'h2;
   localparam logic [3:0] ADDR_PERIOD    = 4'h3;
   localparam logic [3:0] ADDR_TCTRL     = 4'h4;
   localparam logic [3:0] ADDR_TSEL      = 4'h5;
   localparam logic [3:0] ADDR_TCOUNT    = 4'h6;
   localparam logic [3:0] ADDR_FLAGS     = 4'h7;
   localparam logic [3:0] ADDR_DIR       = 4'h8;
   localparam logic [3:0] ADDR_STATUS    = 4'h9;
   // channel control fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_DCB_LSB  = 4;
   localparam logic [3:0] MODE_PWM = 4'hC;
   // timer control fields
   localparam int TCTRL_CKPS_LSB = 0;
   localparam int TCTRL_ON_BIT   = 2;
   localparam int TCTRL_OUTPS_LSB = 3;
   localparam logic [1:0] CKPS_1  = 2'h0;
   localparam logic [1:0] CKPS_4  = 2'h1;
   localparam logic [1:0] CKPS_16 = 2'h2;
   // timer select field width and count of timers
   localparam int TSEL_W    = 2;
   localparam int NUM_TMR   = 3;
   // reset values
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [7:0] RST_PERIOD = 8'hFF;
   localparam logic [7:0] RST_DIR    = 8'h01;
   // last of the four oscillator cycles per timer increment at 1:1
   localparam logic [1:0] Q_LAST = 2'h3;
   typedef enum logic [1:0] {
      SPWM_OFF = 2'b00,
      SPWM_RUN = 2'b01
   } spwm_state_t;
endpackage
